// ===== design/wdt_pkg.sv
package wdt_pkg;

    localparam int unsigned SYS_CLK_HZ = 100_000_000;
    localparam int unsigned WD_CLK_HZ = 1_000;
    localparam int unsigned TICK_DIV_CYCLES = SYS_CLK_HZ / WD_CLK_HZ;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CONTROL = 6'h00;
    localparam logic [5:0] IDX_STATUS = 6'h01;
    localparam logic [5:0] IDX_PROTECT = 6'h02;

    localparam int unsigned PERIOD_LSB = 0;
    localparam int unsigned WINDOW_LSB = 4;
    localparam int unsigned LOCK_BIT = 7;
    localparam int unsigned SYNC_BIT = 0;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] PROTECT_KEY_DEFAULT = 8'h5A; // Arbitrary value
    localparam logic [2:0] PROTECT_WINDOW = 3'h4;
    localparam int unsigned XFER_STAGES = 3;
    localparam logic [3:0] CODE_MAX = 4'hB;
    localparam logic [13:0] TICKS_BASE = 14'h0008;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_NORMAL,
        ST_FIRST,
        ST_CLOSED,
        ST_OPEN
    } wdt_state_t;

    // Reserved codes saturate to the longest period
    function automatic logic [13:0] wdt_ticks(input logic [3:0] code);
        logic [3:0] c;
        c = (code > CODE_MAX) ? CODE_MAX : code;
        if (code == 4'h0) begin
            return 14'h0000;
        end
        return TICKS_BASE << (c - 4'h1);
    endfunction : wdt_ticks

endpackage : wdt_pkg

// ===== design/wdt_tick_xfer.sv
`timescale 1ns/100ps
`default_nettype none
module wdt_tick_xfer #(
    parameter int unsigned STAGES = 3
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Watchdog tick and request
    input wire logic tick_i,
    input wire logic req_i,
    // Transfer state
    output logic busy_o,
    output logic done_o
);
    logic busy_reg;
    logic done_reg;
    logic [1:0] cnt_reg;

    // Requests while busy are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_reg <= 1'b0;
            cnt_reg <= 2'h0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (!busy_reg) begin
                busy_reg <= req_i;
                cnt_reg <= 2'h0;
            end else if (tick_i) begin
                if (cnt_reg == 2'(STAGES - 1)) begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + 2'h1;
                end
            end
        end
    end

    assign busy_o = busy_reg;
    assign done_o = done_reg;

    a_xfer_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        req_i && !busy_reg |=> busy_reg)
        else $error("request not captured");
    a_xfer_done_end: assert property (@(posedge clk_i) disable iff (rst_i)
        done_reg |-> !busy_reg && $past(busy_reg) && $past(tick_i))
        else $error("done without a finishing tick");
endmodule : wdt_tick_xfer
`default_nettype wire

// ===== design/wdt_top.sv
`timescale 1ns/100ps
`default_nettype none
module wdt_top #(
    parameter int unsigned TICK_DIV = wdt_pkg::TICK_DIV_CYCLES,
    parameter logic [7:0] PROTECT_KEY = wdt_pkg::PROTECT_KEY_DEFAULT
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Processor core, debug and fuse configuration
    input wire logic wd_clear_i,
    input wire logic dbg_halt_i,
    input wire logic [7:0] fuse_wd_config_i,
    // Reset controller
    output logic sys_reset_req_o
);
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [7:0] ctrl_reg;
    logic lock_reg;
    logic boot_reg;
    logic [2:0] key_win_reg;
    logic [16:0] div_reg;
    logic tick_reg;
    logic [3:0] per_act_reg;
    logic [3:0] win_act_reg;
    wdt_pkg::wdt_state_t state_reg;
    wdt_pkg::wdt_state_t start_state;
    logic [13:0] cnt_reg;
    logic [13:0] limit;
    logic reset_req_reg;
    logic bus_hit;
    logic bus_wr;
    logic [5:0] bus_idx;
    logic key_write;
    logic prot_ok;
    logic ctrl_wr;
    logic lock_wr;
    logic ctrl_xfer_req;
    logic sync_pending;
    logic ctrl_done;
    logic clr_req;
    logic clr_busy;
    logic clr_done;
    logic expire;
    logic early_clear;

    // Bus decode
    assign bus_hit = cyc_i && stb_i && !ack_reg;
    assign bus_wr = bus_hit && we_i && sel_i[0];
    assign bus_idx = adr_i[7:2];
    assign key_write = bus_wr && bus_idx == wdt_pkg::IDX_PROTECT
        && dat_i[7:0] == PROTECT_KEY;
    assign prot_ok = key_win_reg != 3'h0;
    // Control writes refused while locked or a transfer is running
    assign ctrl_wr = bus_wr && bus_idx == wdt_pkg::IDX_CONTROL && prot_ok
        && !lock_reg && !sync_pending;
    assign lock_wr = bus_wr && bus_idx == wdt_pkg::IDX_STATUS && prot_ok;
    assign ctrl_xfer_req = ctrl_wr || boot_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_hit;
        end
    end

    // Unmapped indices read zero and ignore writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= 32'h0000_0000;
        end else if (bus_hit && !we_i) begin
            case (bus_idx)
                wdt_pkg::IDX_CONTROL: dat_reg <= {24'h00_0000, ctrl_reg};
                wdt_pkg::IDX_STATUS: begin
                    dat_reg <= 32'h0000_0000;
                    dat_reg[wdt_pkg::LOCK_BIT] <= lock_reg;
                    dat_reg[wdt_pkg::SYNC_BIT] <= sync_pending;
                end
                wdt_pkg::IDX_PROTECT: dat_reg <= {29'h0000_0000, key_win_reg};
                default: dat_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Key opens a window of four bus accesses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_win_reg <= 3'h0;
        end else if (key_write) begin
            key_win_reg <= wdt_pkg::PROTECT_WINDOW;
        end else if (ctrl_wr || lock_wr) begin
            key_win_reg <= 3'h0;
        end else if (bus_hit && prot_ok) begin
            key_win_reg <= key_win_reg - 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_reg <= 1'b1;
        end else begin
            boot_reg <= 1'b0;
        end
    end

    // Fuse taken on the first edge after reset release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= wdt_pkg::CONTROL_RESET;
        end else if (boot_reg) begin
            ctrl_reg <= fuse_wd_config_i;
        end else if (ctrl_wr && !key_write) begin
            ctrl_reg <= dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_reg <= 1'b0;
        end else if (boot_reg) begin
            lock_reg <= fuse_wd_config_i[3:0] != 4'h0;
        end else if (lock_wr && dat_i[wdt_pkg::LOCK_BIT]) begin
            lock_reg <= 1'b1;
        end else if (lock_wr && dbg_halt_i) begin
            lock_reg <= 1'b0;
        end
    end

    // Stands in for the oscillator; free running so sleep never stops it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= 17'h0_0000;
            tick_reg <= 1'b0;
        end else if (div_reg == 17'(TICK_DIV - 1)) begin
            div_reg <= 17'h0_0000;
            tick_reg <= 1'b1;
        end else begin
            div_reg <= div_reg + 17'h0_0001;
            tick_reg <= 1'b0;
        end
    end

    wdt_tick_xfer #(
        .STAGES(wdt_pkg::XFER_STAGES)
    ) u_ctrl_xfer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick_reg),
        .req_i(ctrl_xfer_req),
        .busy_o(sync_pending),
        .done_o(ctrl_done)
    );

    assign clr_req = wd_clear_i && !dbg_halt_i;

    wdt_tick_xfer #(
        .STAGES(wdt_pkg::XFER_STAGES)
    ) u_clear_xfer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick_reg),
        .req_i(clr_req),
        .busy_o(clr_busy),
        .done_o(clr_done)
    );

    // Watchdog side sees only transferred settings
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            per_act_reg <= 4'h0;
            win_act_reg <= 4'h0;
        end else if (ctrl_done) begin
            per_act_reg <= ctrl_reg[wdt_pkg::PERIOD_LSB +: 4];
            win_act_reg <= ctrl_reg[wdt_pkg::WINDOW_LSB +: 4];
        end
    end

    // Window mode always waits for a first clear before closing
    always_comb begin
        if (per_act_reg == 4'h0) begin
            start_state = wdt_pkg::ST_OFF;
        end else if (win_act_reg == 4'h0) begin
            start_state = wdt_pkg::ST_NORMAL;
        end else begin
            start_state = wdt_pkg::ST_FIRST;
        end
    end

    always_comb begin
        if (state_reg == wdt_pkg::ST_CLOSED) begin
            limit = wdt_pkg::wdt_ticks(win_act_reg);
        end else begin
            limit = wdt_pkg::wdt_ticks(per_act_reg);
        end
    end

    assign expire = tick_reg && state_reg != wdt_pkg::ST_OFF
        && state_reg != wdt_pkg::ST_CLOSED && cnt_reg == limit - 14'h0001;
    assign early_clear = clr_done && state_reg == wdt_pkg::ST_CLOSED;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= wdt_pkg::ST_OFF;
            cnt_reg <= 14'h0000;
        end else if (dbg_halt_i) begin
            state_reg <= start_state;
            cnt_reg <= 14'h0000;
        end else if (ctrl_done) begin
            state_reg <= wdt_pkg::ST_OFF;
            cnt_reg <= 14'h0000;
        end else if (state_reg == wdt_pkg::ST_OFF && per_act_reg != 4'h0) begin
            state_reg <= start_state;
        end else if (clr_done && state_reg != wdt_pkg::ST_OFF) begin
            cnt_reg <= 14'h0000;
            case (state_reg)
                wdt_pkg::ST_NORMAL: state_reg <= wdt_pkg::ST_NORMAL;
                wdt_pkg::ST_FIRST: state_reg <= wdt_pkg::ST_CLOSED;
                wdt_pkg::ST_CLOSED: state_reg <= start_state;
                wdt_pkg::ST_OPEN: state_reg <= wdt_pkg::ST_CLOSED;
                default: state_reg <= start_state;
            endcase
        end else if (tick_reg && state_reg != wdt_pkg::ST_OFF) begin
            if (cnt_reg == limit - 14'h0001) begin
                cnt_reg <= 14'h0000;
                if (state_reg == wdt_pkg::ST_CLOSED) begin
                    state_reg <= wdt_pkg::ST_OPEN;
                end else begin
                    state_reg <= start_state;
                end
            end else begin
                cnt_reg <= cnt_reg + 14'h0001;
            end
        end
    end

    // One pulse; the reset controller stretches it as needed
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_req_reg <= 1'b0;
        end else begin
            reset_req_reg <= !dbg_halt_i && !ctrl_done
                && !(state_reg == wdt_pkg::ST_OFF)
                && (early_clear || (expire && !clr_done));
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;
    assign sys_reset_req_o = reset_req_reg;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_single: assert property (ack_reg |=> !ack_reg)
        else $error("ack held two cycles");
    a_ack_answer: assert property (cyc_i && stb_i && !ack_reg |=> ack_reg)
        else $error("bus request not answered");
    a_lock_sticky: assert property (
        lock_reg && !dbg_halt_i |=> lock_reg)
        else $error("lock cleared outside debug");
    a_lock_freeze: assert property (lock_reg |=> $stable(ctrl_reg))
        else $error("control changed while locked");
    a_key_needed: assert property (
        $changed(ctrl_reg) && !$past(boot_reg) |->
        $past(key_win_reg) != 3'h0)
        else $error("control changed without key");
    a_key_window: assert property (
        key_write |=> key_win_reg == wdt_pkg::PROTECT_WINDOW)
        else $error("key window not opened");
    a_sync_flag: assert property (
        ctrl_wr |=> sync_pending [*3])
        else $error("sync pending not raised");
    a_halt_hold: assert property (dbg_halt_i |=> cnt_reg == 14'h0000)
        else $error("counter runs during halt");
    a_early_reset: assert property (
        clr_done && state_reg == wdt_pkg::ST_CLOSED && !dbg_halt_i
        && !ctrl_done |=> sys_reset_req_o)
        else $error("early clear did not reset");
    a_first_close: assert property (
        clr_done && state_reg == wdt_pkg::ST_FIRST && !dbg_halt_i
        && !ctrl_done |=> state_reg == wdt_pkg::ST_CLOSED)
        else $error("first clear did not close window");
    a_timeout_reset: assert property (
        expire && !clr_done && !dbg_halt_i && !ctrl_done
        |=> sys_reset_req_o)
        else $error("timeout did not reset");
    a_reset_pulse: assert property (sys_reset_req_o |=> !sys_reset_req_o)
        else $error("reset request longer than one cycle");
    a_enable_map: assert property (
        ctrl_done && !dbg_halt_i |=> ##1
        (state_reg == wdt_pkg::ST_OFF) == (per_act_reg == 4'h0))
        else $error("enable does not follow period");
    a_tick_rate: assert property (
        tick_reg |=> !tick_reg)
        else $error("tick wider than one cycle");

    // Reset request gating and state sequencing
    a_halt_no_reset: assert property (dbg_halt_i |=> !sys_reset_req_o)
        else $error("reset requested during halt");
    a_off_no_reset: assert property (
        state_reg == wdt_pkg::ST_OFF |=> !sys_reset_req_o)
        else $error("reset requested while disabled");
    a_mode_normal: assert property (
        state_reg == wdt_pkg::ST_NORMAL |-> win_act_reg == 4'h0)
        else $error("normal state with window code set");
    a_closed_open: assert property (
        tick_reg && state_reg == wdt_pkg::ST_CLOSED
        && cnt_reg == limit - 14'h0001 && !dbg_halt_i && !ctrl_done
        && !clr_done |=> state_reg == wdt_pkg::ST_OPEN)
        else $error("closed window did not open");
    a_expire_restart: assert property (
        expire && !clr_done && !dbg_halt_i && !ctrl_done
        |=> cnt_reg == 14'h0000)
        else $error("period not restarted after expiry");

    // Register side
    a_fuse_boot: assert property (
        boot_reg |=> ctrl_reg == $past(fuse_wd_config_i))
        else $error("fuse value not loaded");
    a_lock_write_one: assert property (
        lock_wr && dat_i[wdt_pkg::LOCK_BIT] && !boot_reg |=> lock_reg)
        else $error("lock write of one ignored");
    a_ctrl_refused: assert property (
        bus_wr && bus_idx == wdt_pkg::IDX_CONTROL && !prot_ok && !boot_reg
        |=> $stable(ctrl_reg))
        else $error("control changed without key window");
    a_sync_clear: assert property (ctrl_done |-> !sync_pending)
        else $error("sync pending not cleared");
    a_read_unmapped: assert property (
        bus_hit && !we_i && bus_idx > wdt_pkg::IDX_PROTECT
        |=> dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    c_timeout: cover property (expire ##1 sys_reset_req_o);
    c_early: cover property (early_clear);
    c_open_clear: cover property (
        clr_done && state_reg == wdt_pkg::ST_OPEN);
    c_lock_set: cover property (lock_wr ##1 lock_reg);
    c_debug_resume: cover property (dbg_halt_i ##1 !dbg_halt_i);
endmodule : wdt_top
`default_nettype wire

// ===== sim/wdt_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module wdt_core_model #(
    parameter int GAP = 50
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench controls
    input wire logic run_i,
    input wire logic kick_i,
    input wire logic halt_i,
    // Toward the watchdog
    output logic wd_clear_o,
    output logic dbg_halt_o
);
    int cnt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 0;
            wd_clear_o <= 1'b0;
            dbg_halt_o <= 1'b0;
        end else begin
            dbg_halt_o <= halt_i;
            cnt <= (run_i && cnt < GAP) ? cnt + 1 : 0;
            // Halted core executes nothing, so no clears
            wd_clear_o <= !halt_i && (kick_i || (run_i && cnt == GAP));
        end
    end
endmodule : wdt_core_model
`default_nettype wire

// ===== sim/test_windowed_watchdog_timer.sv
`timescale 1ns/100ps
`default_nettype none
module test_windowed_watchdog_timer;
    localparam int DIV = 10;
    localparam logic [7:0] KEY = wdt_pkg::PROTECT_KEY_DEFAULT;
    logic clk_i, rst_i, cyc, stb, we, run, kick, halt, ack, clr, dbg, srst;
    logic [7:0] adr, fuse, q;
    logic [31:0] wdat, rdat;
    int failures, num_checks;

    wdt_top #(.TICK_DIV(DIV)) wdt_top_i (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
        .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .wd_clear_i(clr),
        .dbg_halt_i(dbg), .fuse_wd_config_i(fuse),
        .sys_reset_req_o(srst));
    // Short gap so the first clear lands well inside one period
    wdt_core_model #(.GAP(20)) wdt_core_model_i (.clk_i(clk_i), .rst_i(rst_i),
        .run_i(run), .kick_i(kick), .halt_i(halt), .wd_clear_o(clr),
        .dbg_halt_o(dbg));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk

    // Classic single cycle; waits for ack, bounded
    task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h00_0000, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) begin
            failures++;
            $display("[ERR] ack expected 1 seen 0");
        end
    endtask : bus

    task sync_wait;
        int n;
        n = 0;
        bus(1'b0, 8'h04, 8'h00);
        while (q[0] !== 1'b0 && n < 40) begin
            bus(1'b0, 8'h04, 8'h00);
            n++;
        end
        chk("sync_pending", 8'h00, {7'h00, q[0]});
    endtask : sync_wait

    task set_ctrl(input logic [7:0] v);
        bus(1'b1, 8'h08, KEY);
        bus(1'b1, 8'h00, v);
        bus(1'b0, 8'h04, 8'h00);
        chk("status_after_write", 8'h01, q);
        sync_wait();
    endtask : set_ctrl

    task no_rst(input int c, input string nm);
        int seen;
        seen = 0;
        repeat (c) begin
            @(posedge clk_i);
            if (srst === 1'b1) seen++;
        end
        chk(nm, 8'h00, seen[7:0]);
    endtask : no_rst

    task wait_rst(input int lo, input int hi, input string nm);
        int n;
        n = 0;
        while (srst !== 1'b1 && n <= hi) begin
            @(posedge clk_i);
            n++;
        end
        num_checks++;
        if (n < lo || n > hi) begin
            failures++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, n);
        end
        @(posedge clk_i);
        chk("reset_pulse_width", 8'h00, {7'h00, srst});
    endtask : wait_rst

    task kick_once;
        @(posedge clk_i);
        kick <= 1'b1;
        @(posedge clk_i);
        kick <= 1'b0;
    endtask : kick_once

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        finish_test();
    end

    task test_registers;
        sync_wait();
        bus(1'b0, 8'h04, 8'h00);
        chk("status_boot", 8'h00, q);
        bus(1'b0, 8'h0C, 8'h00);
        chk("unmapped", 8'h00, q);
        bus(1'b1, 8'h00, 8'h01);
        bus(1'b0, 8'h00, 8'h00);
        chk("ctrl_no_key", 8'h00, q);
        bus(1'b1, 8'h08, KEY);
        repeat (4) bus(1'b0, 8'h04, 8'h00);
        bus(1'b1, 8'h00, 8'h01);
        bus(1'b0, 8'h00, 8'h00);
        chk("ctrl_late_key", 8'h00, q);
        bus(1'b1, 8'h04, 8'h80);
        bus(1'b0, 8'h04, 8'h00);
        chk("lock_no_key", 8'h00, q);
        $display("test registers done");
    endtask : test_registers

    task test_normal;
        set_ctrl(8'h01);
        wait_rst(7 * DIV, 10 * DIV, "normal_expiry");
        wait_rst(7 * DIV, 10 * DIV, "normal_restart");
        run <= 1'b1;
        no_rst(40 * DIV, "clears_keep_alive");
        run <= 1'b0;
        $display("test normal done");
    endtask : test_normal

    task test_window;
        set_ctrl(8'h21);
        kick_once();
        no_rst(5 * DIV, "first_clear_open");
        kick_once();
        wait_rst(2 * DIV, 4 * DIV, "early_clear");
        set_ctrl(8'h21);
        kick_once();
        wait_rst(25 * DIV, 29 * DIV, "window_expiry");
        $display("test window done");
    endtask : test_window

    task test_debug;
        set_ctrl(8'h21);
        kick_once();
        repeat (5 * DIV) @(posedge clk_i);
        halt <= 1'b1;
        no_rst(40 * DIV, "halted");
        halt <= 1'b0;
        wait_rst(7 * DIV, 10 * DIV, "after_debug");
        $display("test debug done");
    endtask : test_debug

    task test_lock;
        bus(1'b1, 8'h08, KEY);
        bus(1'b1, 8'h04, 8'h80);
        bus(1'b0, 8'h04, 8'h00);
        chk("lock_set", 8'h80, q);
        bus(1'b1, 8'h08, KEY);
        bus(1'b1, 8'h00, 8'h00);
        bus(1'b0, 8'h00, 8'h00);
        chk("ctrl_locked", 8'h21, q);
        bus(1'b1, 8'h08, KEY);
        bus(1'b1, 8'h04, 8'h00);
        bus(1'b0, 8'h04, 8'h00);
        chk("lock_kept", 8'h80, q);
        halt <= 1'b1;
        bus(1'b1, 8'h08, KEY);
        bus(1'b1, 8'h04, 8'h00);
        bus(1'b0, 8'h04, 8'h00);
        chk("lock_cleared", 8'h00, q);
        halt <= 1'b0;
        set_ctrl(8'h00);
        no_rst(30 * DIV, "disabled");
        $display("test lock done");
    endtask : test_lock

    task test_fuse;
        fuse <= 8'h03;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        sync_wait();
        bus(1'b0, 8'h00, 8'h00);
        chk("ctrl_fuse", 8'h03, q);
        bus(1'b0, 8'h04, 8'h00);
        chk("lock_fuse", 8'h80, q);
        $display("test fuse done");
    endtask : test_fuse

    initial begin
        {cyc, stb, we, run, kick, halt} = 6'h00;
        adr = 8'h00;
        wdat = 32'h0000_0000;
        fuse = 8'h00;
        rst_i = 1'b1;
        failures = 0;
        num_checks = 0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        test_registers();
        test_normal();
        test_window();
        test_debug();
        test_lock();
        test_fuse();
        finish_test();
    end
endmodule : test_windowed_watchdog_timer
`default_nettype wire
